// ---- peripheral_irq_flag_enable_bank.sv ----
// Peripheral interrupt flag and enable bank with an Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pirq_defines.svh"
`default_nettype none

module peripheral_irq_flag_enable_bank
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Avalon-MM slave
  input  wire logic [`PIRQ_ADDR_W-1:0]  address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic      [31:0]              readdata,
  output logic                          waitrequest,
  // Peripheral event pulses
  input  wire logic                     osc_fail_event,
  input  wire logic                     comparator_b_event,
  input  wire logic                     comparator_a_event,
  input  wire logic                     usb_request_event,
  input  wire logic                     collision_a_event,
  input  wire logic                     voltage_detect_event,
  input  wire logic                     timer_c_overflow_event,
  input  wire logic                     capcmp_b_capture_event,
  input  wire logic                     capcmp_b_compare_event,
  input  wire pirq_pkg::capcmp_mode_e   capcmp_b_mode,
  input  wire logic                     sync_serial_b_done_event,
  input  wire logic                     collision_b_event,
  input  wire logic                     timer_d_match_event,
  input  wire logic                     charge_time_event,
  input  wire logic                     timer_c_gate_event,
  input  wire logic                     rtc_event,
  // UART buffer levels
  input  wire logic                     uart_b_rx_buffer_full,
  input  wire logic                     uart_b_tx_buffer_empty,
  // First flag register, held elsewhere
  input  wire logic [7:0]               flag_bank_1,
  // Core enables and package strap
  input  wire logic                     global_enable,
  input  wire logic                     peripheral_global_enable,
  input  wire logic                     priority_mode_enable,
  input  wire logic                     small_package_strap,
  // Requests to the core
  output logic                          periph_pending,
  output logic                          core_request
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pirq_pkg::bus_state_e   state;
  pirq_pkg::bus_state_e   next_state;
  logic [7:0]             enable_1;
  logic [7:0]             enable_2;
  logic [7:0]             enable_3;
  logic [7:0]             flag_2;
  logic [7:0]             flag_3;
  logic                   strap_meta;
  logic                   strap_sync;
  logic                   strap_taken;
  logic                   small_pkg;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire logic       req;
  wire logic       accept;
  wire logic       wr_lane;
  wire logic       hit_en1;
  wire logic       hit_en2;
  wire logic       hit_fl2;
  wire logic       hit_en3;
  wire logic       hit_fl3;
  wire logic [7:0] wdata;
  wire logic [7:0] read_mux;

  assign req      = read | write;
  assign accept   = (state == pirq_pkg::BUS_ACK);
  assign wr_lane  = accept & write & byteenable[0];
  assign wdata    = writedata[7:0];
  assign hit_en1  = (address == `PIRQ_ADDR_ENABLE_1);
  assign hit_en2  = (address == `PIRQ_ADDR_ENABLE_2);
  assign hit_fl2  = (address == `PIRQ_ADDR_FLAG_2);
  assign hit_en3  = (address == `PIRQ_ADDR_ENABLE_3);
  assign hit_fl3  = (address == `PIRQ_ADDR_FLAG_3);

  // Unmapped addresses read zero
  assign read_mux = hit_en1 ? enable_1 :
                    hit_en2 ? enable_2 :
                    hit_fl2 ? flag_2   :
                    hit_en3 ? enable_3 :
                    hit_fl3 ? flag_3   : 8'h00;

  // --------------------------------------------------------------------------
  // Bus handshake: one wait cycle, then one accept cycle
  // --------------------------------------------------------------------------
  always_comb
  begin
    case (state)
      pirq_pkg::BUS_IDLE: next_state = req ? pirq_pkg::BUS_ACK : pirq_pkg::BUS_IDLE;
      pirq_pkg::BUS_ACK:  next_state = pirq_pkg::BUS_IDLE;
      default:            next_state = pirq_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state       <= pirq_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else
    begin
      state       <= next_state;
      waitrequest <= (next_state != pirq_pkg::BUS_ACK);
      readdata    <= {24'h00_0000, read_mux};
    end
  end

  // --------------------------------------------------------------------------
  // Package strap: synchroniser runs through reset, value caught once after it
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    strap_meta <= small_package_strap;
    strap_sync <= strap_meta;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_taken <= 1'b0;
      small_pkg   <= 1'b0;
    end
    else
    begin
      strap_taken <= 1'b1;
      if (strap_taken == 1'b0)
        small_pkg <= strap_sync;
    end
  end

  // --------------------------------------------------------------------------
  // Enables
  // --------------------------------------------------------------------------
  wire logic [7:0] en1_mask;

  assign en1_mask = small_pkg ? 8'h7f : 8'hff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_1 <= `PIRQ_RESET_ENABLE;
      enable_2 <= `PIRQ_RESET_ENABLE;
      enable_3 <= `PIRQ_RESET_ENABLE;
    end
    else
    begin
      if (wr_lane & hit_en1)
        enable_1 <= wdata & en1_mask;
      else
        enable_1 <= enable_1 & en1_mask;
      if (wr_lane & hit_en2)
        enable_2 <= wdata;
      if (wr_lane & hit_en3)
        enable_3 <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Flag events; set wins over a software clear
  // --------------------------------------------------------------------------
  wire logic       capcmp_hit;
  wire logic [7:0] ev2;
  wire logic [7:0] ev3;
  wire logic [7:0] next_flag_2;
  wire logic [7:0] next_flag_3;
  wire logic [7:0] hw_flag_3;

  assign capcmp_hit =
    ((capcmp_b_mode == pirq_pkg::CAPCMP_CAPTURE) & capcmp_b_capture_event) |
    ((capcmp_b_mode == pirq_pkg::CAPCMP_COMPARE) & capcmp_b_compare_event);

  assign ev2[`F2_OSC_FAIL]     = osc_fail_event;
  assign ev2[`F2_COMPARATOR_B] = comparator_b_event;
  assign ev2[`F2_COMPARATOR_A] = comparator_a_event;
  assign ev2[`F2_USB]          = usb_request_event;
  assign ev2[`F2_COLLISION_A]  = collision_a_event;
  assign ev2[`F2_VOLTAGE]      = voltage_detect_event;
  assign ev2[`F2_TIMER_C_OVF]  = timer_c_overflow_event;
  assign ev2[`F2_CAPCMP_B]     = capcmp_hit;

  assign ev3[`F3_SYNC_SERIAL_B] = sync_serial_b_done_event;
  assign ev3[`F3_COLLISION_B]   = collision_b_event;
  assign ev3[`F3_UART_B_RX]     = 1'b0;
  assign ev3[`F3_UART_B_TX]     = 1'b0;
  assign ev3[`F3_TIMER_D_MATCH] = timer_d_match_event;
  assign ev3[`F3_CHARGE_TIME]   = charge_time_event;
  assign ev3[`F3_TIMER_C_GATE]  = timer_c_gate_event;
  assign ev3[`F3_RTC]           = rtc_event;

  // Events set regardless of enables
  assign next_flag_2 = ev2 | ((wr_lane & hit_fl2) ? wdata : flag_2);
  assign hw_flag_3   = {2'b00, uart_b_rx_buffer_full, uart_b_tx_buffer_empty, 4'h0};
  assign next_flag_3 = ((ev3 | ((wr_lane & hit_fl3) ? wdata : flag_3)) & `F3_SW_MASK)
                       | hw_flag_3;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_2 <= `PIRQ_RESET_FLAG;
      flag_3 <= `PIRQ_RESET_FLAG;
    end
    else
    begin
      flag_2 <= next_flag_2;
      flag_3 <= next_flag_3;
    end
  end

  // --------------------------------------------------------------------------
  // Request to the core
  // --------------------------------------------------------------------------
  wire logic [7:0] flag_1_eff;
  wire logic       any_req;
  wire logic       gate_ok;

  assign flag_1_eff = flag_bank_1 & en1_mask;
  // second and first timer flags arrive in the first flag bank
  assign any_req    = |(flag_1_eff & enable_1) | |(flag_2 & enable_2) |
                      |(flag_3 & enable_3);
  assign gate_ok    = global_enable & (priority_mode_enable | peripheral_global_enable);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periph_pending <= 1'b0;
      core_request   <= 1'b0;
    end
    else
    begin
      periph_pending <= any_req;
      core_request   <= any_req & gate_ok;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_OSC_FAIL_SET:
    assert property (osc_fail_event |=> flag_2[`F2_OSC_FAIL])
      else $error("oscillator-fail flag not set");

  AST_COMPARATOR_A_SET:
    assert property (comparator_a_event |=> flag_2[`F2_COMPARATOR_A])
      else $error("comparator a flag not set");

  AST_COMPARATOR_B_SET:
    assert property (comparator_b_event |=> flag_2[`F2_COMPARATOR_B])
      else $error("comparator b flag not set");

  AST_SET_BEATS_CLEAR:
    assert property (usb_request_event && wr_lane && hit_fl2 && !wdata[`F2_USB]
                     |=> flag_2[`F2_USB])
      else $error("usb flag lost to a clear");

  AST_STICKY_FLAG2:
    assert property (flag_2[`F2_COLLISION_A] && !(wr_lane && hit_fl2)
                     |=> flag_2[`F2_COLLISION_A])
      else $error("collision flag dropped without a write");

  AST_PWM_UNUSED:
    assert property (capcmp_b_mode == pirq_pkg::CAPCMP_PWM && !flag_2[`F2_CAPCMP_B]
                     && !(wr_lane && hit_fl2) |=> !flag_2[`F2_CAPCMP_B])
      else $error("capture/compare flag set in pwm mode");

  AST_RX_MIRROR:
    assert property (##1 flag_3[`F3_UART_B_RX] == $past(uart_b_rx_buffer_full))
      else $error("receive flag does not mirror buffer");

  AST_TX_MIRROR:
    assert property (wr_lane && hit_fl3 && !uart_b_tx_buffer_empty
                     |=> !flag_3[`F3_UART_B_TX])
      else $error("transmit flag writable by software");

  AST_PERIPH_GATE:
    assert property (!priority_mode_enable && !peripheral_global_enable
                     |=> !core_request)
      else $error("request passed without peripheral enable");

  AST_SMALL_PKG:
    assert property (small_pkg |-> !enable_1[`F1_PARALLEL_PORT])
      else $error("parallel-port enable set on small package");

  AST_REQUEST_FORM:
    assert property (flag_2 != 8'h00 && enable_2 == flag_2 && gate_ok
                     |=> periph_pending && core_request)
      else $error("enabled flag failed to request");

  AST_SYNC_SERIAL_SET:
    assert property (sync_serial_b_done_event |=> flag_3[`F3_SYNC_SERIAL_B])
      else $error("sync serial flag not set");

  AST_TIMER_D_SET:
    assert property (timer_d_match_event |=> flag_3[`F3_TIMER_D_MATCH])
      else $error("timer d match flag not set");

  AST_RTC_CLEAR:
    assert property (wr_lane && hit_fl3 && !wdata[`F3_RTC] && !rtc_event
                     |=> !flag_3[`F3_RTC])
      else $error("rtc flag not cleared by software");

  AST_ENABLE_WRITE:
    assert property (wr_lane && hit_en3 |=> enable_3 == $past(wdata))
      else $error("enable write did not land");

  AST_FLAG_NO_ENABLE:
    assert property (usb_request_event && !enable_2[`F2_USB] |=> flag_2[`F2_USB])
      else $error("flag not set while disabled");

  AST_PENDING_ZERO:
    assert property (flag_2 == 8'h00 && flag_3 == 8'h00 && (flag_1_eff & enable_1) == 8'h00
                     |=> !periph_pending)
      else $error("request without enabled flag");

  AST_BUS_ANSWER:
    assert property (req && waitrequest && state == pirq_pkg::BUS_IDLE
                     |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle after request");

  COV_WRITE_ENABLE:   cover property (wr_lane && hit_en2);
  COV_CLEAR_FLAG:     cover property (flag_2 != 8'h00 ##1 wr_lane && hit_fl2 ##1 flag_2 == 8'h00);
  COV_CORE_REQUEST:   cover property ($rose(core_request));
  COV_PRIORITY_MODE:  cover property (priority_mode_enable && core_request);
  COV_SMALL_PACKAGE:  cover property ($rose(small_pkg));

endmodule // peripheral_irq_flag_enable_bank

`default_nettype wire

// ---- pirq_defines.svh ----
// Offsets, field positions, reset values and widths of the peripheral flag/enable bank
`ifndef PIRQ_DEFINES_SVH
`define PIRQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define PIRQ_IDX_ENABLE_1   12'hf9d
`define PIRQ_IDX_ENABLE_2   12'hfa0
`define PIRQ_IDX_FLAG_2     12'hfa1
`define PIRQ_IDX_ENABLE_3   12'hfa3
`define PIRQ_IDX_FLAG_3     12'hfa4
`define PIRQ_ADDR_W         14
`define PIRQ_ADDR_ENABLE_1  14'h3e74
`define PIRQ_ADDR_ENABLE_2  14'h3e80
`define PIRQ_ADDR_FLAG_2    14'h3e84
`define PIRQ_ADDR_ENABLE_3  14'h3e8c
`define PIRQ_ADDR_FLAG_3    14'h3e90

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define PIRQ_REG_W          8
`define PIRQ_RESET_ENABLE   8'h00
`define PIRQ_RESET_FLAG     8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define F2_OSC_FAIL         7
`define F2_COMPARATOR_B     6
`define F2_COMPARATOR_A     5
`define F2_USB              4
`define F2_COLLISION_A      3
`define F2_VOLTAGE          2
`define F2_TIMER_C_OVF      1
`define F2_CAPCMP_B         0
`define F3_SYNC_SERIAL_B    7
`define F3_COLLISION_B      6
`define F3_UART_B_RX        5
`define F3_UART_B_TX        4
`define F3_TIMER_D_MATCH    3
`define F3_CHARGE_TIME      2
`define F3_TIMER_C_GATE     1
`define F3_RTC              0
`define F1_PARALLEL_PORT    7
`define F3_SW_MASK          8'hcf

`endif

// ---- pirq_pkg.sv ----
// Types shared by the peripheral flag/enable bank
package pirq_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

  typedef enum logic [2:0]
  {
    CAPCMP_CAPTURE = 3'b001,
    CAPCMP_COMPARE = 3'b010,
    CAPCMP_PWM     = 3'b100
  } capcmp_mode_e;

endpackage

// ---- periph_event_model.sv ----
// Peripheral side model: turns bench requests into registered event pulses that last as long as fire
`timescale 1ns/1ps
`default_nettype none

module periph_event_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Bench request
  input  wire logic        fire,
  input  wire logic [14:0] sel,
  // Event pulses to the bank
  output logic      [14:0] ev
);
  // Registered so pulses leave right after an edge
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ev <= 15'h0000;
    else
      ev <= fire ? sel : 15'h0000;
endmodule // periph_event_model

`default_nettype wire

// ---- test_peripheral_irq_flag_enable_bank.sv ----
// Self-checking bench of the peripheral flag and enable bank
`timescale 1ns/1ps
`include "pirq_defines.svh"
`default_nettype none

module test_peripheral_irq_flag_enable_bank;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  logic [13:0]           address = 14'h0000;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           writedata = 32'h00000000;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  fire = 1'b0;
  logic [14:0]           sel = 15'h0000;
  logic [14:0]           ev;
  pirq_pkg::capcmp_mode_e mode = pirq_pkg::CAPCMP_CAPTURE;
  logic                  rx_full = 1'b0;
  logic                  tx_empty = 1'b0;
  logic [7:0]            bank_1 = 8'h00;
  logic                  ge = 1'b0;
  logic                  pge = 1'b0;
  logic                  pm = 1'b0;
  logic                  strap = 1'b0;
  logic                  periph_pending;
  logic                  core_request;
  int                    fails = 0;
  int                    checked = 0;
  int                    cyc = 0;
  // Expected {flag_2, flag_3} per event line
  localparam logic [15:0] EXP_TAB [15] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0100, 16'h0080, 16'h0040,
    16'h0008, 16'h0004, 16'h0002, 16'h0001};

  always #25 clk = ~clk;

  periph_event_model periph_event_model_i
  (.clk(clk), .rstn(rstn), .fire(fire), .sel(sel), .ev(ev));

  peripheral_irq_flag_enable_bank peripheral_irq_flag_enable_bank_i
  (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .osc_fail_event(ev[0]), .comparator_b_event(ev[1]),
    .comparator_a_event(ev[2]), .usb_request_event(ev[3]), .collision_a_event(ev[4]),
    .voltage_detect_event(ev[5]), .timer_c_overflow_event(ev[6]),
    .capcmp_b_capture_event(ev[7]), .capcmp_b_compare_event(ev[8]),
    .capcmp_b_mode(mode), .sync_serial_b_done_event(ev[9]), .collision_b_event(ev[10]),
    .timer_d_match_event(ev[11]), .charge_time_event(ev[12]),
    .timer_c_gate_event(ev[13]), .rtc_event(ev[14]), .uart_b_rx_buffer_full(rx_full),
    .uart_b_tx_buffer_empty(tx_empty), .flag_bank_1(bank_1), .global_enable(ge),
    .peripheral_global_enable(pge), .priority_mode_enable(pm),
    .small_package_strap(strap), .periph_pending(periph_pending),
    .core_request(core_request)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp1(input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp8(e, q);
  endtask

  task automatic fire_ev(input logic [14:0] s);
    @(posedge clk);
    fire <= 1'b1;
    sel <= s;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic chk_req(input logic p, input logic c);
    repeat (3) @(posedge clk);
    cmp1(p, periph_pending);
    cmp1(c, core_request);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(`PIRQ_ADDR_ENABLE_1, 8'h00);
    rd(`PIRQ_ADDR_ENABLE_2, 8'h00);
    rd(`PIRQ_ADDR_ENABLE_3, 8'h00);
    rd(`PIRQ_ADDR_FLAG_2, 8'h00);
    rd(`PIRQ_ADDR_FLAG_3, 8'h00);
    wr(14'h0004, 8'hff);
    rd(14'h0004, 8'h00);
    wr(`PIRQ_ADDR_ENABLE_1, 8'hff);
    wr(`PIRQ_ADDR_ENABLE_2, 8'ha5);
    wr(`PIRQ_ADDR_ENABLE_3, 8'h5a);
    rd(`PIRQ_ADDR_ENABLE_1, 8'hff);
    rd(`PIRQ_ADDR_ENABLE_2, 8'ha5);
    rd(`PIRQ_ADDR_ENABLE_3, 8'h5a);
    wr(`PIRQ_ADDR_ENABLE_1, 8'h00);
    wr(`PIRQ_ADDR_ENABLE_2, 8'h00);
    wr(`PIRQ_ADDR_ENABLE_3, 8'h00);
    $display("done t_regs");
  endtask

  task automatic t_events();
    for (int i = 0; i < 15; i++)
    begin
      mode <= (i == 8) ? pirq_pkg::CAPCMP_COMPARE : pirq_pkg::CAPCMP_CAPTURE;
      wr(`PIRQ_ADDR_FLAG_2, 8'h00);
      wr(`PIRQ_ADDR_FLAG_3, 8'h00);
      fire_ev(15'(1 << i));
      rd(`PIRQ_ADDR_FLAG_2, EXP_TAB[i][15:8]);
      rd(`PIRQ_ADDR_FLAG_3, EXP_TAB[i][7:0]);
      cmp1(1'b0, periph_pending);
    end
    mode <= pirq_pkg::CAPCMP_PWM;
    wr(`PIRQ_ADDR_FLAG_2, 8'h00);
    fire_ev(15'h0180);
    rd(`PIRQ_ADDR_FLAG_2, 8'h00);
    wr(`PIRQ_ADDR_FLAG_3, 8'h00);
    fire <= 1'b1;
    sel <= 15'h0008;
    wr(`PIRQ_ADDR_FLAG_2, 8'h00);
    fire <= 1'b0;
    rd(`PIRQ_ADDR_FLAG_2, 8'h10);
    wr(`PIRQ_ADDR_FLAG_2, 8'h00);
    rd(`PIRQ_ADDR_FLAG_2, 8'h00);
    $display("done t_events");
  endtask

  task automatic t_uart();
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    rd(`PIRQ_ADDR_FLAG_3, 8'h30);
    wr(`PIRQ_ADDR_FLAG_3, 8'h00);
    rd(`PIRQ_ADDR_FLAG_3, 8'h30);
    rx_full <= 1'b0;
    wr(`PIRQ_ADDR_FLAG_3, 8'hff);
    rd(`PIRQ_ADDR_FLAG_3, 8'hdf);
    tx_empty <= 1'b0;
    wr(`PIRQ_ADDR_FLAG_3, 8'h30);
    rd(`PIRQ_ADDR_FLAG_3, 8'h00);
    $display("done t_uart");
  endtask

  task automatic t_request();
    ge <= 1'b1;
    pge <= 1'b1;
    wr(`PIRQ_ADDR_ENABLE_2, 8'h10);
    fire_ev(15'h0008);
    chk_req(1'b1, 1'b1);
    pge <= 1'b0;
    chk_req(1'b1, 1'b0);
    pm <= 1'b1;
    chk_req(1'b1, 1'b1);
    ge <= 1'b0;
    chk_req(1'b1, 1'b0);
    ge <= 1'b1;
    pm <= 1'b0;
    pge <= 1'b1;
    wr(`PIRQ_ADDR_FLAG_2, 8'h00);
    chk_req(1'b0, 1'b0);
    bank_1 <= 8'h01;
    wr(`PIRQ_ADDR_ENABLE_1, 8'h01);
    chk_req(1'b1, 1'b1);
    bank_1 <= 8'h02;
    chk_req(1'b0, 1'b0);
    wr(`PIRQ_ADDR_ENABLE_1, 8'h02);
    chk_req(1'b1, 1'b1);
    wr(`PIRQ_ADDR_ENABLE_1, 8'h00);
    chk_req(1'b0, 1'b0);
    $display("done t_request");
  endtask

  task automatic t_small();
    rstn <= 1'b0;
    strap <= 1'b1;
    bank_1 <= 8'h80;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wr(`PIRQ_ADDR_ENABLE_1, 8'hff);
    rd(`PIRQ_ADDR_ENABLE_1, 8'h7f);
    chk_req(1'b0, 1'b0);
    $display("done t_small");
  endtask

  // ----------------------------------------------------------------
  // Verdict and run control
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_events();
    t_uart();
    t_request();
    t_small();
    stop_test();
  end
endmodule // test_peripheral_irq_flag_enable_bank

`default_nettype wire
